// ===== testbench/epiv_core_model.sv
// processor core model that enters the vectors offered by the block
`timescale 1ns/1ps
module epiv_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_valid,
  input wire logic [4:0] irq_vec,
  input wire logic [3:0] ack_delay,
  output logic irq_ack,
  output int served,
  output logic [4:0] last_vec
);
  logic [3:0] wait_cnt;
  // ----------------------------------------------------------------
  // vector entry
  // ----------------------------------------------------------------
  // no second ack while the first is still being taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      served <= 0;
      last_vec <= 5'h00;
      wait_cnt <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      if (irq_valid && !irq_ack) begin
        if (wait_cnt >= ack_delay) begin
          irq_ack <= 1'b1;
          served <= served + 1;
          last_vec <= irq_vec;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the external pin interrupt vector block
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic ext_req_pin_a, ext_req_pin_b, io_clk_run, irq_ack, irq_valid, wake_req;
  logic [27:0] pin_change_inputs;
  logic [12:0] periph_req;
  logic [4:0] irq_vec, last_vec;
  logic [3:0] ack_delay;
  int served, fails, checks_done;

  epiv_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_req_pin_a(ext_req_pin_a),
    .ext_req_pin_b(ext_req_pin_b), .pin_change_inputs(pin_change_inputs),
    .periph_req(periph_req), .io_clk_run(io_clk_run), .irq_ack(irq_ack),
    .irq_valid(irq_valid), .irq_vec(irq_vec), .wake_req(wake_req));
  epiv_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid),
    .irq_vec(irq_vec), .ack_delay(ack_delay), .irq_ack(irq_ack), .served(served),
    .last_vec(last_vec));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(a, 1'b1, d, rd, err);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(a, 1'b0, 32'h0, rd, err);
    chk(rd, exp);
  endtask
  task automatic wait_serve(input int base, input logic [4:0] exp);
    int n;
    n = 0;
    while (served == base && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk(served > base, 32'h1);
    chk(last_vec, exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] rd;
    logic err;
    chk(irq_valid, 1'b0);
    chk(irq_vec, epiv_pkg::VEC_RESET);
    rd_chk(epiv_pkg::OFF_SENSE, {28'h0, epiv_pkg::SENSE_RST});
    apb(8'hF0, 1'b1, 32'hFFFFFFFF, rd, err);
    chk(err, 1'b1);
    apb(8'hF0, 1'b0, 32'h0, rd, err);
    chk(rd, 32'h0);
  endtask
  task automatic t_modes;
    epiv_pkg::epiv_sense_t modes [3];
    logic [2:0] ef, er;
    modes = '{epiv_pkg::SENSE_FALL, epiv_pkg::SENSE_RISE, epiv_pkg::SENSE_ANY};
    ef = 3'h5;
    er = 3'h6;
    wr(epiv_pkg::OFF_EXT_EN, 32'h1);
    // both pins in the same mode, so each edge sense code (fall, rise, any) is seen on each pin
    for (int m = 0; m < 3; m++) begin
      wr(epiv_pkg::OFF_SENSE, {28'h0, modes[m], modes[m]});
      wr(epiv_pkg::OFF_EXT_FLAG, 32'h3);
      ext_req_pin_a <= 1'b0;
      ext_req_pin_b <= 1'b0;
      cyc(8);
      rd_chk(epiv_pkg::OFF_EXT_FLAG, {30'h0, {2{ef[m]}}});
      wr(epiv_pkg::OFF_EXT_FLAG, 32'h3);
      rd_chk(epiv_pkg::OFF_EXT_FLAG, 32'h0);
      ext_req_pin_a <= 1'b1;
      ext_req_pin_b <= 1'b1;
      cyc(8);
      rd_chk(epiv_pkg::OFF_EXT_FLAG, {30'h0, {2{er[m]}}});
      wr(epiv_pkg::OFF_EXT_FLAG, 32'h3);
    end
  endtask
  task automatic t_ack;
    int base;
    base = served;
    wr(epiv_pkg::OFF_CTRL, 32'h1);
    wr(epiv_pkg::OFF_SENSE, 32'hA);
    ext_req_pin_a <= 1'b0;
    wait_serve(base, epiv_pkg::VEC_EXT_A);
    rd_chk(epiv_pkg::OFF_EXT_FLAG, 32'h0);
    ext_req_pin_a <= 1'b1;
    wr(epiv_pkg::OFF_CTRL, 32'h0);
    wr(epiv_pkg::OFF_EXT_EN, 32'h2);
    base = served;
    ext_req_pin_b <= 1'b0;
    cyc(10);
    chk(served, base);
    wr(epiv_pkg::OFF_CTRL, 32'h1);
    wait_serve(base, epiv_pkg::VEC_EXT_B);
    ext_req_pin_b <= 1'b1;
  endtask
  task automatic t_level;
    int base;
    base = served;
    wr(epiv_pkg::OFF_SENSE, 32'h2);
    ext_req_pin_b <= 1'b0;
    cyc(40);
    chk(served >= base + 2, 32'h1);
    chk(last_vec, epiv_pkg::VEC_EXT_B);
    rd_chk(epiv_pkg::OFF_EXT_FLAG, 32'h0);
    ext_req_pin_b <= 1'b1;
    cyc(12);
    chk(irq_valid, 1'b0);
    wr(epiv_pkg::OFF_EXT_EN, 32'h0);
  endtask
  task automatic t_groups;
    int base;
    for (int g = 0; g < 4; g++) begin
      wr(epiv_pkg::OFF_PC_EN, 32'h1 << g);
      wr(epiv_pkg::OFF_MASK0 + 8'(4 * g), 32'h2);
      base = served;
      pin_change_inputs[g * 8] <= ~pin_change_inputs[g * 8];
      cyc(10);
      chk(served, base);
      pin_change_inputs[g * 8 + 1] <= ~pin_change_inputs[g * 8 + 1];
      wait_serve(base, epiv_pkg::VEC_PC0 + 5'(g));
      wr(epiv_pkg::OFF_MASK0 + 8'(4 * g), 32'h0);
    end
    wr(epiv_pkg::OFF_PC_EN, 32'h0);
  endtask
  task automatic t_periph;
    int base;
    for (int i = 0; i < 13; i++) begin
      base = served;
      periph_req[i] <= 1'b1;
      wait_serve(base, epiv_pkg::VEC_WDOG + 5'(i));
      periph_req[i] <= 1'b0;
      cyc(8);
    end
  endtask
  task automatic t_prio;
    int base;
    wr(epiv_pkg::OFF_CTRL, 32'h0);
    wr(epiv_pkg::OFF_PC_FLAG, 32'hF);
    wr(epiv_pkg::OFF_PC_EN, 32'h1);
    wr(epiv_pkg::OFF_MASK0, 32'h4);
    periph_req[0] <= 1'b1;
    pin_change_inputs[2] <= ~pin_change_inputs[2];
    cyc(10);
    base = served;
    wr(epiv_pkg::OFF_CTRL, 32'h1);
    wait_serve(base, epiv_pkg::VEC_PC0);
    wait_serve(base + 1, epiv_pkg::VEC_WDOG);
    periph_req[0] <= 1'b0;
    cyc(8);
  endtask
  task automatic t_sleep;
    int base;
    int n;
    // slow core entry stands in for the start-up time after wake
    ack_delay <= 4'hF;
    wr(epiv_pkg::OFF_PC_EN, 32'h0);
    wr(epiv_pkg::OFF_EXT_EN, 32'h1);
    wr(epiv_pkg::OFF_SENSE, 32'h2);
    io_clk_run <= 1'b0;
    ext_req_pin_a <= 1'b0;
    cyc(10);
    rd_chk(epiv_pkg::OFF_EXT_FLAG, 32'h0);
    chk(wake_req, 1'b0);
    ext_req_pin_a <= 1'b1;
    cyc(8);
    wr(epiv_pkg::OFF_SENSE, 32'h0);
    base = served;
    ext_req_pin_a <= 1'b0;
    cyc(8);
    chk(wake_req, 1'b1);
    ext_req_pin_a <= 1'b1;
    cyc(8);
    io_clk_run <= 1'b1;
    cyc(12);
    chk(served, base);
    io_clk_run <= 1'b0;
    ext_req_pin_a <= 1'b0;
    cyc(8);
    io_clk_run <= 1'b1;
    wait_serve(base, epiv_pkg::VEC_EXT_A);
    ext_req_pin_a <= 1'b1;
    wr(epiv_pkg::OFF_EXT_EN, 32'h0);
    wr(epiv_pkg::OFF_PC_EN, 32'h1);
    wr(epiv_pkg::OFF_MASK0, 32'h1);
    io_clk_run <= 1'b0;
    pin_change_inputs[0] <= ~pin_change_inputs[0];
    // a change wakes for one cycle only, so watch for it
    n = 0;
    while (wake_req !== 1'b1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
    chk(wake_req, 1'b1);
    io_clk_run <= 1'b1;
  endtask
  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    fails = 0;
    checks_done = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {ext_req_pin_a, ext_req_pin_b} = 2'h3;
    pin_change_inputs = 28'hFFFFFFF;
    periph_req = 13'h0;
    io_clk_run = 1'b1;
    ack_delay = 4'h2;
    cyc(3);
    presetn <= 1'b1;
    cyc(8);
    t_reset();
    t_modes();
    t_ack();
    t_level();
    t_groups();
    ack_delay <= 4'h0;
    t_periph();
    ack_delay <= 4'h5;
    t_prio();
    t_sleep();
    give_verdict();
  end
  // cuts a hang well beyond the several hundred cycles the run needs
  initial begin
    #200000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule

// ===== verilog/epiv_pkg.sv
// constants and types shared by the external pin interrupt vector block
package epiv_pkg;
  // ----------------------------------------------------------------
  // vector program addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_EXT_A = 5'h01;
  localparam logic [4:0] VEC_EXT_B = 5'h02;
  localparam logic [4:0] VEC_PC0 = 5'h03;
  localparam logic [4:0] VEC_PC3 = 5'h06;
  localparam logic [4:0] VEC_WDOG = 5'h07;
  localparam logic [4:0] VEC_WIDE_CAP = 5'h08;
  localparam logic [4:0] VEC_WIDE_WRAP = 5'h0B;
  localparam logic [4:0] VEC_NAR_MA = 5'h0C;
  localparam logic [4:0] VEC_NAR_WRAP = 5'h0E;
  localparam logic [4:0] VEC_SERIAL = 5'h0F;
  localparam logic [4:0] VEC_TWO_WIRE = 5'h13;
  localparam int NVEC = 20;
  localparam int NPERIPH = 13;
  localparam int NPIN = 28;
  // ----------------------------------------------------------------
  // pin change groups
  // ----------------------------------------------------------------
  localparam logic [3:0][27:0] PC_GRP_MASK = {
    28'hF000000, 28'h0FF0000, 28'h000FF00, 28'h00000FF};
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SENSE = 8'h00;
  localparam logic [7:0] OFF_EXT_EN = 8'h04;
  localparam logic [7:0] OFF_EXT_FLAG = 8'h08;
  localparam logic [7:0] OFF_PC_EN = 8'h0C;
  localparam logic [7:0] OFF_PC_FLAG = 8'h10;
  localparam logic [7:0] OFF_MASK0 = 8'h14;
  localparam logic [7:0] OFF_MASK1 = 8'h18;
  localparam logic [7:0] OFF_MASK2 = 8'h1C;
  localparam logic [7:0] OFF_MASK3 = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'h24;
  localparam logic [7:0] OFF_PINS = 8'h28;
  localparam logic [7:0] OFF_VEC = 8'h2C;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SENSE_RST = 4'h0;
  localparam logic [29:0] PIN_RST = 30'h3FFFFFFF;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SENSE_LOW = 2'h0,
    SENSE_ANY = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } epiv_sense_t;
  typedef struct packed {
    logic valid;
    logic [4:0] vec;
  } epiv_irq_t;
endpackage

// ===== verilog/epiv_top.sv
// external pin interrupt detection and vector dispatch, APB slave
// What this block does
// - reset entry sits at address 0x000
// - pin a to 0x001, pin b to 0x002
// - change groups 0..3 to 0x003..0x006
// - watchdog 0x007, wide timer 0x008..0x00B
// - narrow timer requests to 0x00C..0x00E
// - serial..two-wire requests to 0x00F..0x013
// - pins request even when driven as outputs
// - toggle on enabled group input raises request
// - per-group mask selects contributing inputs
// - pin change detected without I/O clock
// - dedicated pins sense fall, rise, any change or low
// - level mode requests while pin stays low
// - edge sensing needs running I/O clock
// - low level detected without I/O clock
// - only asynchronous detectors wake deep sleep
// - short waking low level raises no interrupt
// - short level wake resumes after sleep
// - sense codes low, any, fall, rise
// - pulse over two clocks always detected
// - edge flag cleared by entry or one
// - pin request needs own and global enable, peripheral request only global
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module epiv_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_req_pin_a,
  input wire logic ext_req_pin_b,
  input wire logic [27:0] pin_change_inputs,
  input wire logic [12:0] periph_req,
  input wire logic io_clk_run,
  input wire logic irq_ack,
  output logic irq_valid,
  output logic [4:0] irq_vec,
  output logic wake_req
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [29:0] sync1_reg;
  logic [29:0] sync2_reg;
  logic [29:0] sync3_reg;
  logic [29:0] filt_reg;
  logic [29:0] prev_reg;
  logic [3:0] sense_reg;
  logic [1:0] ext_en_reg;
  logic [1:0] ext_flag_reg;
  logic [3:0] pc_en_reg;
  logic [3:0] pc_flag_reg;
  logic [27:0] mask_reg;
  logic gie_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  epiv_pkg::epiv_irq_t irq_reg;
  epiv_pkg::epiv_irq_t irq_next;
  logic wake_reg;
  logic [29:0] pins_w;
  logic [27:0] pc_chg;
  logic [3:0] grp_chg;
  logic [1:0] edge_w;
  logic [1:0] low_w;
  logic [1:0] ext_req_w;
  logic [19:0] req_w;
  logic setup;
  logic access;
  logic wr;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(
    input logic [1:0] s,
    input logic c,
    input logic p
  );
    case (s)
      epiv_pkg::SENSE_ANY: edge_hit = c ^ p;
      epiv_pkg::SENSE_FALL: edge_hit = p & ~c;
      epiv_pkg::SENSE_RISE: edge_hit = c & ~p;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [4:0] prio(input logic [19:0] r);
    prio = epiv_pkg::VEC_RESET;
    for (int i = 19; i >= 1; i--) begin
      if (r[i]) begin
        prio = 5'(i);
      end
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      epiv_pkg::OFF_SENSE, epiv_pkg::OFF_EXT_EN,
      epiv_pkg::OFF_EXT_FLAG, epiv_pkg::OFF_PC_EN,
      epiv_pkg::OFF_PC_FLAG, epiv_pkg::OFF_MASK0,
      epiv_pkg::OFF_MASK1, epiv_pkg::OFF_MASK2,
      epiv_pkg::OFF_MASK3, epiv_pkg::OFF_CTRL,
      epiv_pkg::OFF_PINS, epiv_pkg::OFF_VEC: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pad levels are sampled whatever the pin direction, so a pin driven
  // by the port itself still triggers
  assign pins_w = {ext_req_pin_b, ext_req_pin_a, pin_change_inputs};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= epiv_pkg::PIN_RST;
      sync2_reg <= epiv_pkg::PIN_RST;
      sync3_reg <= epiv_pkg::PIN_RST;
    end else begin
      sync1_reg <= pins_w;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // a level is accepted once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_reg <= epiv_pkg::PIN_RST;
      prev_reg <= epiv_pkg::PIN_RST;
    end else begin
      filt_reg <= (~(sync2_reg ^ sync3_reg) & sync2_reg)
        | ((sync2_reg ^ sync3_reg) & filt_reg);
      prev_reg <= filt_reg;
    end
  end

  // ----------------------------------------------------------------
  // pin change groups
  // ----------------------------------------------------------------
  assign pc_chg = (filt_reg[27:0] ^ prev_reg[27:0]) & mask_reg;

  for (genvar g = 0; g < 4; g++) begin : g_grp
    assign grp_chg[g] = |(pc_chg & epiv_pkg::PC_GRP_MASK[g]);
  end

  // flag set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_flag_reg <= 4'h0;
    end else begin
      for (int g = 0; g < 4; g++) begin
        if (grp_chg[g]) begin
          pc_flag_reg[g] <= 1'b1;
        end else if (wr && paddr == epiv_pkg::OFF_PC_FLAG && pwdata[g]) begin
          pc_flag_reg[g] <= 1'b0;
        end else if (irq_ack && irq_reg.vec == 5'(g + 3)) begin
          pc_flag_reg[g] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // dedicated request pins
  // ----------------------------------------------------------------
  for (genvar e = 0; e < 2; e++) begin : g_ext
    // edges only count while the I/O clock runs
    assign edge_w[e] = io_clk_run
      && edge_hit(sense_reg[2*e+1 -: 2], filt_reg[28+e], prev_reg[28+e]);
    assign low_w[e] = sense_reg[2*e+1 -: 2] == epiv_pkg::SENSE_LOW
      && !filt_reg[28+e];
    // level requests are never latched: a level gone before start-up
    // ends leaves nothing pending, so the core just resumes
    assign ext_req_w[e] = ext_en_reg[e]
      && (low_w[e] || ext_flag_reg[e]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_flag_reg <= 2'h0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        if (sense_reg[2*e+1 -: 2] == epiv_pkg::SENSE_LOW) begin
          ext_flag_reg[e] <= 1'b0;
        end else if (edge_w[e]) begin
          ext_flag_reg[e] <= 1'b1;
        end else if (wr && paddr == epiv_pkg::OFF_EXT_FLAG && pwdata[e]) begin
          ext_flag_reg[e] <= 1'b0;
        end else if (irq_ack && irq_reg.vec == 5'(e + 1)) begin
          ext_flag_reg[e] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // vector dispatch
  // ----------------------------------------------------------------
  // bit index equals program address; bit 0 is the reset entry
  always_comb begin
    req_w = 20'h00000;
    req_w[epiv_pkg::VEC_EXT_A] = ext_req_w[0];
    req_w[epiv_pkg::VEC_EXT_B] = ext_req_w[1];
    req_w[epiv_pkg::VEC_PC3:epiv_pkg::VEC_PC0] = pc_flag_reg & pc_en_reg;
    req_w[epiv_pkg::VEC_TWO_WIRE:epiv_pkg::VEC_WDOG] = periph_req;
    if (!gie_reg) begin
      req_w = 20'h00000;
    end
  end

  always_comb begin
    irq_next.valid = (|req_w) && !irq_ack;
    irq_next.vec = prio(req_w);
  end

  // the vector output parks at the reset entry after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= '{valid: 1'b0, vec: epiv_pkg::VEC_RESET};
    end else begin
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // wake from deep sleep
  // ----------------------------------------------------------------
  // with the I/O clock stopped only level and pin change paths wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= !io_clk_run
        && (|(low_w & ext_en_reg) || |(grp_chg & pc_en_reg));
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable && pready_reg;
  assign wr = access && pwrite;

  // one wait-free access: data and error prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped(paddr);
      prdata_reg <= 32'h00000000;
      if (setup && !pwrite) begin
        case (paddr)
          epiv_pkg::OFF_SENSE: prdata_reg <= {28'h0, sense_reg};
          epiv_pkg::OFF_EXT_EN: prdata_reg <= {30'h0, ext_en_reg};
          epiv_pkg::OFF_EXT_FLAG: prdata_reg <= {30'h0, ext_flag_reg};
          epiv_pkg::OFF_PC_EN: prdata_reg <= {28'h0, pc_en_reg};
          epiv_pkg::OFF_PC_FLAG: prdata_reg <= {28'h0, pc_flag_reg};
          epiv_pkg::OFF_MASK0: prdata_reg <= {24'h0, mask_reg[7:0]};
          epiv_pkg::OFF_MASK1: prdata_reg <= {24'h0, mask_reg[15:8]};
          epiv_pkg::OFF_MASK2: prdata_reg <= {24'h0, mask_reg[23:16]};
          epiv_pkg::OFF_MASK3: prdata_reg <= {28'h0, mask_reg[27:24]};
          epiv_pkg::OFF_CTRL: prdata_reg <= {31'h0, gie_reg};
          epiv_pkg::OFF_PINS: prdata_reg <= {2'h0, filt_reg};
          epiv_pkg::OFF_VEC: prdata_reg <= {26'h0, irq_reg};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_reg <= epiv_pkg::SENSE_RST;
      ext_en_reg <= 2'h0;
      pc_en_reg <= 4'h0;
      mask_reg <= 28'h0000000;
      gie_reg <= 1'b0;
    end else if (wr) begin
      case (paddr)
        epiv_pkg::OFF_SENSE: sense_reg <= pwdata[3:0];
        epiv_pkg::OFF_EXT_EN: ext_en_reg <= pwdata[1:0];
        epiv_pkg::OFF_PC_EN: pc_en_reg <= pwdata[3:0];
        epiv_pkg::OFF_MASK0: mask_reg[7:0] <= pwdata[7:0];
        epiv_pkg::OFF_MASK1: mask_reg[15:8] <= pwdata[7:0];
        epiv_pkg::OFF_MASK2: mask_reg[23:16] <= pwdata[7:0];
        epiv_pkg::OFF_MASK3: mask_reg[27:24] <= pwdata[3:0];
        epiv_pkg::OFF_CTRL: gie_reg <= pwdata[0];
        default: gie_reg <= gie_reg;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_valid = irq_reg.valid;
  assign irq_vec = irq_reg.vec;
  assign wake_req = wake_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [19:0] below_w;
  assign below_w = 20'((20'h00001 << irq_reg.vec) - 20'h00001);

  chk_level_flag_clr: assert property (
    sense_reg[1:0] == epiv_pkg::SENSE_LOW |=> !ext_flag_reg[0])
    else $error("flag a set in level mode");

  chk_level_request: assert property (
    gie_reg && ext_en_reg[0] && low_w[0] && !irq_ack
    |=> irq_valid && irq_vec == epiv_pkg::VEC_EXT_A)
    else $error("low level on pin a not dispatched");

  chk_lowest_first: assert property (
    irq_valid |-> ($past(req_w) & below_w) == 20'h00000)
    else $error("lower vector was pending");

  chk_global_gate: assert property (
    !gie_reg |=> !irq_valid)
    else $error("request passed with global enable off");

  chk_edge_frozen: assert property (
    !io_clk_run && !ext_flag_reg[1] |=> !ext_flag_reg[1])
    else $error("edge seen with I/O clock stopped");

  chk_group_toggle: assert property (
    grp_chg[1] |=> pc_flag_reg[1])
    else $error("group one change lost");

  chk_mask_block: assert property (
    mask_reg[7:0] == 8'h00 && !pc_flag_reg[0] |=> !pc_flag_reg[0])
    else $error("masked inputs set group zero flag");

  chk_sleep_wake: assert property (
    !io_clk_run && |(grp_chg & pc_en_reg) |=> wake_req)
    else $error("pin change did not wake");

  chk_pin_latency: assert property (
    sense_reg[3:2] == epiv_pkg::SENSE_RISE && io_clk_run
    && $rose(sync3_reg[29]) && sync2_reg[29]
    ##1 (sense_reg[3:2] == epiv_pkg::SENSE_RISE && io_clk_run)[*2]
    |=> ext_flag_reg[1] || sense_reg[3:2] != epiv_pkg::SENSE_RISE)
    else $error("rising edge on pin b missed");

  chk_vec_range: assert property (
    irq_valid |-> irq_vec >= epiv_pkg::VEC_EXT_A
    && irq_vec <= epiv_pkg::VEC_TWO_WIRE)
    else $error("vector outside table");

  cov_level_irq: cover property (irq_valid && irq_vec == epiv_pkg::VEC_EXT_A);
  cov_group_irq: cover property (irq_valid && irq_vec == epiv_pkg::VEC_PC3);
  cov_wake: cover property (wake_req);
  cov_two_pending: cover property (req_w[1] && req_w[7]);
endmodule
